/* pkg/pcf_pkg.sv */
package pcf_pkg;

	// Lock interval at the core clock rate
	localparam int unsigned  LOCK_TIME_US = 50;
	localparam int unsigned  MCLK_MHZ     = 100;
	localparam int unsigned  LOCK_CYCLES  = LOCK_TIME_US * MCLK_MHZ;
	localparam int           LOCK_W       = 13;

	// Reference counted as present while an edge came within this many cycles
	localparam int           TMO_W        = 6;
	localparam logic [5:0]   REF_TMO_CYC  = 6'h20;

	// Cycles without a new phase correction while a slip travels the feedback path
	localparam int           GUARD_W        = 4;
	localparam logic [3:0]   SLIP_GUARD_CYC = 4'hC;

	// Divider chain and reset values
	localparam logic [2:0]   DIV_RST      = 3'h0;
	localparam int           BANK_N       = 3;
	localparam logic         OE_N_RST     = 1'b1;
	localparam logic         STRAP_RST    = 1'b0;

	typedef enum logic [1:0]
	{
		PCF_HOLD   = 2'h0,
		PCF_ACQ    = 2'h1,
		PCF_LOCK   = 2'h3,
		PCF_BYPASS = 2'h2
	} pcf_lock_e;

	typedef struct packed
	{
		logic [BANK_N-1:0] clk;
		logic [BANK_N-1:0] oe;
	} pcf_bank_s;

	typedef struct packed
	{
		pcf_lock_e         fsm;
		logic [LOCK_W-1:0] lock_cnt;
		logic              locked;
		logic [2:0]        div;
		logic [TMO_W-1:0]  ref_tmo;
		logic              ref_prev;
		logic              fb_prev;
		logic              sel_prev;
		logic              oe_n_prev;
		logic              test_prev;
		logic              slip;
		logic [GUARD_W-1:0] guard;
		pcf_bank_s         b1;
		pcf_bank_s         b2;
	} pcf_state_s;

endpackage

/* rtl/pcf_sync.sv */
`timescale 1ns/100ps
module pcf_sync
	import pcf_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
)
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	input  wire logic ce,
	// Pin side
	input  wire logic pin,
	// Core side
	output logic      lvl
);

	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} pcf_sync_s;

	localparam pcf_sync_s SYNC_RST = '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};

	pcf_sync_s st_ff;
	pcf_sync_s nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		if (ce)
		begin
			nxt_st.s1 = pin;
			nxt_st.s2 = st_ff.s1;
			nxt_st.s3 = st_ff.s2;
			// Accept a change only once the second and third stages agree
			if (st_ff.s2 == st_ff.s3)
				nxt_st.lvl = st_ff.s3;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			st_ff <= SYNC_RST;
		else
			st_ff <= nxt_st;
	end

	assign lvl = st_ff.lvl;

endmodule

/* rtl/pcf_top.sv */
`timescale 1ns/100ps
module pcf_top
	import pcf_pkg::*;
#(
	parameter int unsigned LOCK_CYC = LOCK_CYCLES
)
(
	// Clock, reset and clock enable
	input  wire logic  mclk,
	input  wire logic  nrst,
	input  wire logic  ce,
	// Clock pins
	input  wire logic  reference_clock_in,
	input  wire logic  feedback_clock_in,
	// Straps and control pins
	input  wire logic  output_enable_n,
	input  wire logic  config_select,
	input  wire logic  test_bypass,
	input  wire logic  factory_clear_pin,
	// Output banks, clock level and per-pin drive enable
	output pcf_bank_s  bank_one_clock_outs,
	output pcf_bank_s  bank_two_clock_outs,
	// Status
	output logic       pll_locked
);

	localparam logic [LOCK_W-1:0] LOCK_LOAD = LOCK_W'(LOCK_CYC);
	localparam logic [LOCK_W-1:0] LOCK_ONE  = 13'h0001;

	localparam pcf_state_s ST_RST = '{
		fsm:       PCF_HOLD,
		lock_cnt:  LOCK_LOAD,
		locked:    1'b0,
		div:       DIV_RST,
		ref_tmo:   '0,
		ref_prev:  STRAP_RST,
		fb_prev:   STRAP_RST,
		sel_prev:  STRAP_RST,
		oe_n_prev: OE_N_RST,
		test_prev: STRAP_RST,
		slip:      1'b0,
		guard:     '0,
		b1:        '0,
		b2:        '0
	};

	pcf_state_s st_ff;
	pcf_state_s nxt_st;

	logic ref_lvl;
	logic fb_lvl;
	logic oe_n_lvl;
	logic sel_lvl;
	logic test_lvl;

	pcf_sync #(.RST_VAL(STRAP_RST)) u_ref  (.mclk(mclk), .nrst(nrst), .ce(ce), .pin(reference_clock_in), .lvl(ref_lvl));
	pcf_sync #(.RST_VAL(STRAP_RST)) u_fb   (.mclk(mclk), .nrst(nrst), .ce(ce), .pin(feedback_clock_in),  .lvl(fb_lvl));
	pcf_sync #(.RST_VAL(OE_N_RST))  u_oe   (.mclk(mclk), .nrst(nrst), .ce(ce), .pin(output_enable_n),    .lvl(oe_n_lvl));
	pcf_sync #(.RST_VAL(STRAP_RST)) u_sel  (.mclk(mclk), .nrst(nrst), .ce(ce), .pin(config_select),      .lvl(sel_lvl));
	pcf_sync #(.RST_VAL(STRAP_RST)) u_test (.mclk(mclk), .nrst(nrst), .ce(ce), .pin(test_bypass),        .lvl(test_lvl));

	// Factory clear is left unconnected to any state
	logic clr_unused;
	assign clr_unused = factory_clear_pin;

	logic       ref_rise;
	logic       fb_rise;
	logic       ref_valid;
	logic       restart;
	logic       hold;
	logic [2:0] div_nxt;
	logic       half_clk;
	logic       quarter_clk;

	always_comb
	begin
		nxt_st      = st_ff;
		ref_rise    = ref_lvl & ~st_ff.ref_prev;
		fb_rise     = fb_lvl & ~st_ff.fb_prev;
		ref_valid   = (st_ff.ref_tmo != '0);
		div_nxt     = st_ff.div;
		half_clk    = 1'b0;
		quarter_clk = 1'b0;
		// Any change of the loop's reference or feedback path restarts acquisition
		restart = (sel_lvl != st_ff.sel_prev)
			| (~oe_n_lvl & st_ff.oe_n_prev)
			| (~test_lvl & st_ff.test_prev)
			| (ref_rise & ~ref_valid)
			| st_ff.slip;
		hold = oe_n_lvl | ~ref_valid;
		if (ce)
		begin
			nxt_st.ref_prev  = ref_lvl;
			nxt_st.fb_prev   = fb_lvl;
			nxt_st.sel_prev  = sel_lvl;
			nxt_st.oe_n_prev = oe_n_lvl;
			nxt_st.test_prev = test_lvl;
			if (ref_rise)
				nxt_st.ref_tmo = REF_TMO_CYC;
			else if (ref_valid)
				nxt_st.ref_tmo = st_ff.ref_tmo - 6'h01;

			// Phase detector: hold the divider one cycle per unmatched reference edge;
			// the guard waits out the feedback path so one error is not corrected twice
			nxt_st.slip = ref_rise & ~fb_rise & ~test_lvl & (st_ff.guard == '0);
			if (nxt_st.slip)
				nxt_st.guard = SLIP_GUARD_CYC;
			else if (st_ff.guard != '0)
				nxt_st.guard = st_ff.guard - 4'h1;
			if (!nxt_st.slip)
				div_nxt = st_ff.div + 3'h1;
			// Bit 0 stands for the oscillator, so the half rate holds each level at least two cycles
			// and the fed-back output still passes the pin filter
			nxt_st.div  = div_nxt;
			half_clk    = ~div_nxt[1];
			quarter_clk = div_nxt[2];

			case (st_ff.fsm)
				PCF_HOLD:
				begin
					nxt_st.lock_cnt = LOCK_LOAD;
					nxt_st.locked   = 1'b0;
					if (test_lvl)
						nxt_st.fsm = PCF_BYPASS;
					else if (!hold)
						nxt_st.fsm = PCF_ACQ;
				end
				PCF_ACQ:
				begin
					nxt_st.locked = 1'b0;
					if (test_lvl)
						nxt_st.fsm = PCF_BYPASS;
					else if (hold)
						nxt_st.fsm = PCF_HOLD;
					else if (restart)
						nxt_st.lock_cnt = LOCK_LOAD;
					else if (st_ff.lock_cnt == LOCK_ONE)
					begin
						nxt_st.lock_cnt = '0;
						nxt_st.locked   = 1'b1;
						nxt_st.fsm      = PCF_LOCK;
					end
					else
						nxt_st.lock_cnt = st_ff.lock_cnt - LOCK_ONE;
				end
				PCF_LOCK:
				begin
					if (test_lvl)
					begin
						nxt_st.fsm    = PCF_BYPASS;
						nxt_st.locked = 1'b0;
					end
					else if (hold | restart)
					begin
						nxt_st.fsm      = hold ? PCF_HOLD : PCF_ACQ;
						nxt_st.lock_cnt = LOCK_LOAD;
						nxt_st.locked   = 1'b0;
					end
				end
				PCF_BYPASS:
				begin
					nxt_st.locked   = 1'b0;
					nxt_st.lock_cnt = LOCK_LOAD;
					if (!test_lvl)
						nxt_st.fsm = PCF_HOLD;
				end
				default:
				begin
					nxt_st.fsm = PCF_HOLD;
				end
			endcase

			// Output banks
			if (test_lvl)
			begin
				nxt_st.b1.clk = {BANK_N{ref_lvl}};
				nxt_st.b2.clk = {BANK_N{ref_lvl}};
			end
			else
			begin
				nxt_st.b1.clk = {BANK_N{sel_lvl ? quarter_clk : half_clk}};
				nxt_st.b2.clk = {BANK_N{half_clk}};
			end
			nxt_st.b1.oe = {BANK_N{~oe_n_lvl}};
			nxt_st.b2.oe = {BANK_N{~oe_n_lvl}};
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	assign bank_one_clock_outs = st_ff.b1;
	assign bank_two_clock_outs = st_ff.b2;
	assign pll_locked          = st_ff.locked;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst || !ce);

	oe_float_a: assert property (ce |=> bank_one_clock_outs.oe == {BANK_N{~$past(oe_n_lvl)}}
		&& bank_two_clock_outs.oe == {BANK_N{~$past(oe_n_lvl)}})
		else $error("output drive enable does not follow output enable");

	oe_relock_a: assert property (ce && !oe_n_lvl && st_ff.oe_n_prev |=> !pll_locked)
		else $error("lock kept across output re-enable");

	lock_time_a: assert property ($rose(pll_locked) |-> $past(st_ff.lock_cnt) == LOCK_ONE
		&& $past(st_ff.fsm) == PCF_ACQ)
		else $error("lock declared before the acquisition interval ended");

	phase_slip_a: assert property (ce && !test_lvl && ref_rise && !fb_rise && st_ff.guard == '0
		|=> st_ff.div == $past(st_ff.div))
		else $error("divider not held on unmatched reference edge");

	bypass_path_a: assert property (ce && test_lvl |=> bank_two_clock_outs.clk == {BANK_N{$past(ref_lvl)}}
		&& !pll_locked)
		else $error("bypass does not pass the reference");

	bank_one_rate_a: assert property (ce && !test_lvl |=> bank_one_clock_outs.clk
		== {BANK_N{$past(sel_lvl) ? st_ff.div[2] : ~st_ff.div[1]}})
		else $error("bank one rate does not follow select");

	bank_two_rate_a: assert property (ce && !test_lvl |=> bank_two_clock_outs.clk == {BANK_N{~st_ff.div[1]}})
		else $error("bank two not at half rate");

	duty_half_a: assert property (ce && !test_lvl ##1 ce && !test_lvl && !nxt_st.slip
		##1 ce && !test_lvl && !nxt_st.slip
		|=> bank_two_clock_outs.clk[0] != $past(bank_two_clock_outs.clk[0], 2))
		else $error("half rate output lost its even duty");

	sel_relock_a: assert property (ce && st_ff.fsm == PCF_LOCK && sel_lvl != st_ff.sel_prev
		|=> !pll_locked ##1 !pll_locked)
		else $error("lock kept across select change");

	edge_align_a: assert property (ce && !test_lvl && sel_lvl |=> $rose(st_ff.div[2])
		|-> $fell(st_ff.div[1]))
		else $error("quarter rising edge not on a half rising edge");

	rate_mix_a: assert property (ce && !test_lvl && !sel_lvl |=> bank_one_clock_outs.clk
		== bank_two_clock_outs.clk)
		else $error("select low but banks differ");

endmodule

/* testbench/pcf_partner.sv */
`timescale 1ns/100ps
module pcf_partner
	import pcf_pkg::*;
(
	// Clock and control
	input  wire logic      mclk,
	input  wire logic      ref_run,
	// Fed-back bank
	input  wire pcf_bank_s bank_two_clock_outs,
	// Pins toward the block
	output logic           reference_clock_in,
	output logic           feedback_clock_in
);
	logic float_ff;
	logic ph_ff;

	initial
	begin
		reference_clock_in = 1'b0;
		float_ff = 1'b0;
		ph_ff = 1'b0;
	end

	// Fixed-rate reference at the half-rate output frequency; stands still while stopped
	always @(posedge mclk)
	begin
		float_ff <= ~float_ff;
		ph_ff <= ~ph_ff;
		if (ref_run && ph_ff)
			reference_clock_in <= ~reference_clock_in;
	end

	// One output wired back; a floating line shows a changing pattern
	assign feedback_clock_in = bank_two_clock_outs.oe[0] ? bank_two_clock_outs.clk[0] : float_ff;
endmodule

/* testbench/test_pcf_top.sv */
`timescale 1ns/100ps
module test_pcf_top;
	import pcf_pkg::*;
	localparam int unsigned LCYC = 20;
	logic      mclk;
	logic      nrst = 1'b0;
	logic      oe_n = 1'b1;
	logic      sel = 1'b0;
	logic      tst = 1'b0;
	logic      clr = 1'b0;
	logic      ref_run = 1'b1;
	logic      ref_in;
	logic      fb_in;
	pcf_bank_s b1;
	pcf_bank_s b2;
	logic      locked;
	int        mismatches = 0;
	int        n_checks = 0;
	int        cycles = 0;
	int        tg1, tg2, hi1, bad;

	pcf_top #(.LOCK_CYC(LCYC)) DUT (.mclk(mclk), .nrst(nrst), .ce(1'b1), .reference_clock_in(ref_in),
		.feedback_clock_in(fb_in), .output_enable_n(oe_n), .config_select(sel), .test_bypass(tst),
		.factory_clear_pin(clr), .bank_one_clock_outs(b1), .bank_two_clock_outs(b2), .pll_locked(locked));
	pcf_partner far (.mclk(mclk), .ref_run(ref_run), .bank_two_clock_outs(b2),
		.reference_clock_in(ref_in), .feedback_clock_in(fb_in));

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic check_bit(string what, logic exp, logic got);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic check_int(string what, int exp, int got);
		n_checks++;
		if (got != exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic drive(logic o, logic s, logic t, int settle);
		@(posedge mclk);
		oe_n <= o;
		sel <= s;
		tst <= t;
		repeat (settle) @(negedge mclk);
	endtask

	// Counts toggles and highs over eight cycles; flags a slow rise without a fast one
	task automatic measure();
		logic p1;
		logic p2;
		tg1 = 0;
		tg2 = 0;
		hi1 = 0;
		bad = 0;
		@(negedge mclk);
		p1 = b1.clk[0];
		p2 = b2.clk[0];
		repeat (8)
		begin
			@(negedge mclk);
			tg1 += (b1.clk[0] !== p1);
			tg2 += (b2.clk[0] !== p2);
			hi1 += (b1.clk[0] === 1'b1);
			bad += (p1 === 1'b0 && b1.clk[0] === 1'b1 && !(p2 === 1'b0 && b2.clk[0] === 1'b1));
			p1 = b1.clk[0];
			p2 = b2.clk[0];
		end
	endtask

	// Lock must not come early, and must come in time
	task automatic expect_lock();
		int n;
		n = 0;
		while (locked !== 1'b1 && n < LCYC + 60)
		begin
			@(negedge mclk);
			n++;
		end
		check_bit("pll_locked", 1'b1, locked);
		check_int("lock_not_early", 1, int'(n >= LCYC - 8));
	endtask

	task automatic t_enable_half();
		drive(1'b0, 1'b0, 1'b0, 8);
		check_bit("b1.oe", 1'b1, &b1.oe === 1'b1);
		check_bit("b2.oe", 1'b1, &b2.oe === 1'b1);
		check_bit("pll_locked", 1'b0, locked);
		expect_lock();
		measure();
		check_int("b1 toggles", 4, tg1);
		check_int("b2 toggles", 4, tg2);
		check_int("b1 highs", 4, hi1);
		repeat (4)
		begin
			@(negedge mclk);
			check_bit("feedback phase", ref_in, fb_in);
		end
	endtask

	task automatic t_quarter();
		drive(1'b0, 1'b1, 1'b0, 8);
		check_bit("pll_locked", 1'b0, locked);
		expect_lock();
		measure();
		check_int("b1 toggles", 2, tg1);
		check_int("b1 highs", 4, hi1);
		check_int("b2 toggles", 4, tg2);
		check_int("lone slow rise", 0, bad);
	endtask

	task automatic t_disable_reenable();
		drive(1'b1, 1'b1, 1'b0, 8);
		check_bit("b1.oe", 1'b1, |b1.oe === 1'b0);
		check_bit("b2.oe", 1'b1, |b2.oe === 1'b0);
		drive(1'b0, 1'b1, 1'b0, 8);
		check_bit("pll_locked", 1'b0, locked);
		expect_lock();
	endtask

	task automatic t_clear_ignored();
		@(posedge mclk);
		clr <= 1'b1;
		repeat (12) @(negedge mclk);
		check_bit("pll_locked", 1'b1, locked);
		measure();
		check_int("b1 toggles", 2, tg1);
		@(posedge mclk);
		clr <= 1'b0;
	endtask

	task automatic t_bypass();
		drive(1'b0, 1'b1, 1'b1, 8);
		check_bit("pll_locked", 1'b0, locked);
		@(posedge mclk);
		ref_run <= 1'b0;
		repeat (10) @(negedge mclk);
		measure();
		check_int("b2 toggles", 0, tg2);
		@(posedge mclk);
		ref_run <= 1'b1;
		repeat (8) @(negedge mclk);
		measure();
		check_int("b1 toggles", 4, tg1);
		drive(1'b0, 1'b1, 1'b0, 2);
		expect_lock();
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge mclk);
		check_bit("b1 in reset", 1'b1, b1 === 6'h00);
		check_bit("pll_locked", 1'b0, locked);
		nrst <= 1'b1;
		t_enable_half();
		t_quarter();
		t_disable_reenable();
		t_clear_ignored();
		t_bypass();
		tally_and_finish();
	end
endmodule
